// ### logic/adfc_top.sv
`timescale 1ns/1ps
module adfc_top
#(
  parameter int unsigned RECOVERY_CYCLES = adfc_pkg::PWR_RECOVERY_CYCLES
)
(
  // Clock and reset
  input  wire logic                                    CORE_CLK,
  input  wire logic                                    RSTN,
  // Converter static controls
  input  wire logic                                    OUTPUT_SCRAMBLE_SEL,
  input  wire logic                                    GAIN_SELECT,
  input  wire logic                                    ADC_POWER_DOWN,
  input  wire logic                                    DITHER_ENABLE,
  input  wire logic                                    FORMAT_SEL,
  input  wire logic                                    OUT_MODE_SEL,
  // Digitised front-end samples, two's complement
  input  wire logic [3:0][adfc_pkg::SAMPLE_W-1:0]      RAW_SAMPLE,
  // FIFO controls
  input  wire logic                                    FIFO_WEN_N,
  input  wire logic [3:0]                              FIFO_REN_N,
  input  wire logic [3:0]                              FIFO_OE_N,
  input  wire logic                                    PARTIAL_CLEAR_N,
  input  wire logic                                    FULL_CLEAR_N,
  // Converter outputs
  output logic      [3:0][adfc_pkg::SAMPLE_W-1:0]      ADC_DATA,
  output logic                                         ADC_DATA_OE,
  output logic                                         ADC_READY,
  output logic                                         DITHER_ACTIVE,
  // FIFO outputs
  output logic      [3:0][adfc_pkg::SAMPLE_W-1:0]      FIFO_DATA,
  output logic      [3:0]                              FIFO_DATA_OE,
  output logic      [3:0]                              FULL_FLAG_N,
  output logic      [3:0]                              EMPTY_FLAG_N,
  output logic      [3:0][adfc_pkg::LEVEL_W-1:0]       FIFO_LEVEL
);
  localparam logic [adfc_pkg::RECOVERY_CNT_W-1:0] REC_LAST =
    adfc_pkg::RECOVERY_CNT_W'(RECOVERY_CYCLES - 1);
  localparam logic [adfc_pkg::RECOVERY_CNT_W-1:0] REC_ZERO = 20'h00000;
  localparam logic [adfc_pkg::RECOVERY_CNT_W-1:0] REC_ONE  = 20'h00001;

  typedef enum logic [1:0] {PWR_OFF, PWR_RECOVER, PWR_ON} adfc_pwr_type;

  adfc_pwr_type                           pwr_r;
  adfc_pwr_type                           pwr_nxt;
  logic [adfc_pkg::RECOVERY_CNT_W-1:0]    rec_cnt_r;
  logic [adfc_pkg::RECOVERY_CNT_W-1:0]    rec_cnt_nxt;
  logic [3:0][adfc_pkg::SAMPLE_W-1:0]     conv_nxt;
  logic [3:0][adfc_pkg::SAMPLE_W-1:0]     adc_data_r;
  logic                                   adc_vld_r;
  wire                                    adc_vld_nxt;
  wire                                    rec_done;

  assign rec_done = (rec_cnt_r >= REC_LAST);

  // Power-down and recovery sequencing
  always_comb
  begin
    pwr_nxt     = pwr_r;
    rec_cnt_nxt = rec_cnt_r;
    case (pwr_r)
      PWR_OFF:
      begin
        rec_cnt_nxt = REC_ZERO;
        if (!ADC_POWER_DOWN)
          pwr_nxt = PWR_RECOVER;
      end
      PWR_RECOVER:
      begin
        if (ADC_POWER_DOWN)
          pwr_nxt = PWR_OFF;
        else if (rec_done)
          pwr_nxt = PWR_ON;
        else
          rec_cnt_nxt = rec_cnt_r + REC_ONE;
      end
      PWR_ON:
      begin
        if (ADC_POWER_DOWN)
          pwr_nxt = PWR_OFF;
      end
      default:
        pwr_nxt = PWR_OFF;
    endcase
  end

  // Sample path per channel
  always_comb
  begin
    conv_nxt = '0;
    for (int c = 0; c < adfc_pkg::NUM_CHAN; c++)
    begin
      conv_nxt[c] = adfc_pkg::apply_scramble(
                      adfc_pkg::apply_format(
                        adfc_pkg::apply_gain(RAW_SAMPLE[c],
                                             GAIN_SELECT),
                        FORMAT_SEL),
                      OUTPUT_SCRAMBLE_SEL);
    end
  end

  // Full-rate parallel words only in the ground mode
  assign adc_vld_nxt = (pwr_r == PWR_ON) && !ADC_POWER_DOWN
                    && !OUT_MODE_SEL;

  always_ff @(posedge CORE_CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      pwr_r     <= PWR_OFF;
      rec_cnt_r <= REC_ZERO;
    end
    else
    begin
      pwr_r     <= pwr_nxt;
      rec_cnt_r <= rec_cnt_nxt;
    end
  end

  always_ff @(posedge CORE_CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      adc_data_r    <= '0;
      adc_vld_r     <= 1'b0;
      ADC_DATA      <= '0;
      ADC_DATA_OE   <= 1'b0;
      ADC_READY     <= 1'b0;
      DITHER_ACTIVE <= 1'b0;
    end
    else
    begin
      adc_vld_r     <= adc_vld_nxt;
      adc_data_r    <= adc_vld_nxt ? conv_nxt : '0;
      ADC_DATA      <= adc_vld_nxt ? conv_nxt : '0;
      ADC_DATA_OE   <= !ADC_POWER_DOWN;
      ADC_READY     <= (pwr_nxt == PWR_ON);
      DITHER_ACTIVE <= DITHER_ENABLE && !ADC_POWER_DOWN;
    end
  end

  // One FIFO per converter channel
  for (genvar c = 0; c < adfc_pkg::NUM_CHAN; c++)
  begin : g_fifo
    adfc_chan_fifo u_fifo
    (
      .clk             (CORE_CLK),
      .rstn            (RSTN),
      .wr_vld          (adc_vld_r),
      .wr_data         (adc_data_r[c]),
      .wr_en_n         (FIFO_WEN_N),
      .rd_en_n         (FIFO_REN_N[c]),
      .oe_n            (FIFO_OE_N[c]),
      .partial_clear_n (PARTIAL_CLEAR_N),
      .full_clear_n    (FULL_CLEAR_N),
      .rd_data         (FIFO_DATA[c]),
      .rd_oe           (FIFO_DATA_OE[c]),
      .full_flag_n     (FULL_FLAG_N[c]),
      .empty_flag_n    (EMPTY_FLAG_N[c]),
      .level           (FIFO_LEVEL[c])
    );
  end
endmodule

// ### common/adfc_pkg.sv
package adfc_pkg;
  localparam int unsigned NUM_CHAN       = 4;
  localparam int unsigned SAMPLE_W       = 16;
  localparam int unsigned FIFO_ADDR_W    = 16;
  localparam int unsigned FIFO_DEPTH     = 65536;
  localparam int unsigned LEVEL_W        = FIFO_ADDR_W + 1;
  localparam int unsigned CLK_PERIOD_NS  = 25;
  localparam int unsigned PWR_RECOVERY_MS = 20;
  localparam int unsigned NS_PER_MS      = 1000000;
  localparam int unsigned PWR_RECOVERY_CYCLES =
    (PWR_RECOVERY_MS * NS_PER_MS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned RECOVERY_CNT_W = 20;
  localparam logic [SAMPLE_W-1:0] SAMPLE_ZERO = 16'h0000;
  localparam logic [SAMPLE_W-1:0] SAT_POS     = 16'h7fff;
  localparam logic [SAMPLE_W-1:0] SAT_NEG     = 16'h8000;
  localparam logic [SAMPLE_W-1:0] MSB_MASK    = 16'h8000;
  localparam logic [LEVEL_W-1:0]  LEVEL_FULL  = 17'h10000;
  localparam logic [LEVEL_W-1:0]  LEVEL_ZERO  = 17'h00000;
  localparam logic [LEVEL_W-1:0]  LEVEL_ONE   = 17'h00001;
  localparam logic [FIFO_ADDR_W-1:0] ADDR_ZERO = 16'h0000;
  localparam logic [FIFO_ADDR_W-1:0] ADDR_ONE  = 16'h0001;

  // Unity or 1.5 gain with saturation
  function automatic logic [SAMPLE_W-1:0] apply_gain(
    input logic [SAMPLE_W-1:0] s,
    input logic                hi
  );
    logic signed [SAMPLE_W+1:0] w;
    w = $signed({{2{s[SAMPLE_W-1]}}, s})
      + $signed({{3{s[SAMPLE_W-1]}}, s[SAMPLE_W-1:1]});
    if (!hi)
      apply_gain = s;
    else if (w > $signed({2'b00, SAT_POS}))
      apply_gain = SAT_POS;
    else if (w < $signed({2'b11, SAT_NEG}))
      apply_gain = SAT_NEG;
    else
      apply_gain = w[SAMPLE_W-1:0];
  endfunction

  // Two's complement or offset binary
  function automatic logic [SAMPLE_W-1:0] apply_format(
    input logic [SAMPLE_W-1:0] s,
    input logic                twos
  );
    apply_format = twos ? s : (s ^ MSB_MASK);
  endfunction

  // Upper bits XORed with the LSB
  function automatic logic [SAMPLE_W-1:0] apply_scramble(
    input logic [SAMPLE_W-1:0] s,
    input logic                on
  );
    apply_scramble = on ? (s ^ {{(SAMPLE_W-1){s[0]}}, 1'b0}) : s;
  endfunction
endpackage

// ### logic/adfc_chan_fifo.sv
`timescale 1ns/1ps
module adfc_chan_fifo
(
  // Clock and reset
  input  wire logic                                clk,
  input  wire logic                                rstn,
  // Write side
  input  wire logic                                wr_vld,
  input  wire logic [adfc_pkg::SAMPLE_W-1:0]       wr_data,
  input  wire logic                                wr_en_n,
  // Read side
  input  wire logic                                rd_en_n,
  input  wire logic                                oe_n,
  // Clears
  input  wire logic                                partial_clear_n,
  input  wire logic                                full_clear_n,
  // Data and state
  output logic      [adfc_pkg::SAMPLE_W-1:0]       rd_data,
  output logic                                     rd_oe,
  output logic                                     full_flag_n,
  output logic                                     empty_flag_n,
  output logic      [adfc_pkg::LEVEL_W-1:0]        level
);
  logic [adfc_pkg::SAMPLE_W-1:0]    mem [adfc_pkg::FIFO_DEPTH];
  logic [adfc_pkg::FIFO_ADDR_W-1:0] wr_ptr_r;
  logic [adfc_pkg::FIFO_ADDR_W-1:0] rd_ptr_r;
  logic [adfc_pkg::LEVEL_W-1:0]     level_r;
  logic [adfc_pkg::LEVEL_W-1:0]     level_nxt;
  logic [adfc_pkg::SAMPLE_W-1:0]    rd_word_r;
  wire                              clearing;
  wire                              do_wr;
  wire                              do_rd;

  assign clearing = !partial_clear_n || !full_clear_n;
  assign do_wr = !clearing && wr_vld && !wr_en_n
              && (level_r != adfc_pkg::LEVEL_FULL);
  assign do_rd = !clearing && !rd_en_n
              && (level_r != adfc_pkg::LEVEL_ZERO);
  assign level_nxt = (do_wr && !do_rd) ? level_r + adfc_pkg::LEVEL_ONE
                   : (do_rd && !do_wr) ? level_r - adfc_pkg::LEVEL_ONE
                   : level_r;
  assign rd_data      = rd_word_r;
  assign level        = level_r;

  always_ff @(posedge clk)
  begin
    if (do_wr)
      mem[wr_ptr_r] <= wr_data;
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      wr_ptr_r     <= adfc_pkg::ADDR_ZERO;
      rd_ptr_r     <= adfc_pkg::ADDR_ZERO;
      level_r      <= adfc_pkg::LEVEL_ZERO;
      rd_word_r    <= adfc_pkg::SAMPLE_ZERO;
      rd_oe        <= 1'b0;
      full_flag_n  <= 1'b1;
      empty_flag_n <= 1'b0;
    end
    else
    begin
      rd_oe <= !oe_n;
      if (clearing)
      begin
        wr_ptr_r     <= adfc_pkg::ADDR_ZERO;
        rd_ptr_r     <= adfc_pkg::ADDR_ZERO;
        level_r      <= adfc_pkg::LEVEL_ZERO;
        full_flag_n  <= 1'b1;
        empty_flag_n <= 1'b0;
        if (!full_clear_n)
          rd_word_r <= adfc_pkg::SAMPLE_ZERO;
      end
      else
      begin
        if (do_wr)
          wr_ptr_r <= wr_ptr_r + adfc_pkg::ADDR_ONE;
        if (do_rd)
        begin
          rd_ptr_r  <= rd_ptr_r + adfc_pkg::ADDR_ONE;
          rd_word_r <= mem[rd_ptr_r];
        end
        level_r      <= level_nxt;
        full_flag_n  <= (level_nxt != adfc_pkg::LEVEL_FULL);
        empty_flag_n <= (level_nxt != adfc_pkg::LEVEL_ZERO);
      end
    end
  end
endmodule

// ### testbench/adfc_top_assertions.sv
`timescale 1ns/1ps
module adfc_top_chk
#(
  parameter int unsigned RECOVERY_CYCLES = 8
)
(
  // Clock and reset
  input wire logic             CORE_CLK,
  input wire logic             RSTN,
  // Converter controls and samples
  input wire logic             OUTPUT_SCRAMBLE_SEL,
  input wire logic             GAIN_SELECT,
  input wire logic             ADC_POWER_DOWN,
  input wire logic             DITHER_ENABLE,
  input wire logic             FORMAT_SEL,
  input wire logic             OUT_MODE_SEL,
  input wire logic [3:0][15:0] RAW_SAMPLE,
  // Watched outputs
  input wire logic [3:0][15:0] ADC_DATA,
  input wire logic             ADC_DATA_OE,
  input wire logic             ADC_READY,
  input wire logic             DITHER_ACTIVE,
  input wire logic [3:0]       FULL_FLAG_N,
  input wire logic [3:0]       EMPTY_FLAG_N,
  input wire logic [3:0][16:0] FIFO_LEVEL
);
  localparam int unsigned R_MAX = RECOVERY_CYCLES + 4;
  logic [3:0][15:0] raw_r;
  logic             scr_r, fmt_r, go_r;
  logic [31:0]      cnt_r, cnt_nxt;
  logic             vld;
  assign cnt_nxt = ADC_POWER_DOWN ? 32'h0 : cnt_r + 32'h1;
  assign vld = go_r && ADC_READY;
  // Counts cycles since power down and remembers the controls and sample of the previous edge
  always_ff @(posedge CORE_CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      go_r  <= 1'b0;
      cnt_r <= 32'h0;
    end
    else
    begin
      go_r  <= ADC_READY && !OUT_MODE_SEL && !ADC_POWER_DOWN && !GAIN_SELECT;
      cnt_r <= cnt_nxt;
    end
  end
  always_ff @(posedge CORE_CLK)
  begin
    raw_r <= RAW_SAMPLE;
    scr_r <= OUTPUT_SCRAMBLE_SEL;
    fmt_r <= FORMAT_SEL;
  end
  default clocking cb @(posedge CORE_CLK);
  endclocking
  default disable iff (!RSTN);
  scramble_out_a:
    assert property (vld && scr_r && fmt_r
      |-> ADC_DATA[0] == (raw_r[0] ^ {{15{raw_r[0][0]}}, 1'b0}))
    else $error("scrambled word wrong");
  unity_gain_a:
    assert property (vld && !scr_r && fmt_r |-> ADC_DATA[1] == raw_r[1])
    else $error("unity gain word wrong");
  offset_fmt_a:
    assert property (vld && !scr_r && !fmt_r
      |-> ADC_DATA[2] == (raw_r[2] ^ 16'h8000))
    else $error("offset binary word wrong");
  power_blank_a:
    assert property (ADC_POWER_DOWN
      |=> !ADC_DATA_OE && !ADC_READY && ADC_DATA == '0)
    else $error("outputs not blanked in power down");
  recovery_wait_a:
    assert property ($rose(ADC_READY) |-> cnt_r >= RECOVERY_CYCLES)
    else $error("ready before recovery time");
  ready_bound_a:
    assert property (cnt_r > R_MAX |-> ADC_READY)
    else $error("ready late after recovery");
  dither_follow_a:
    assert property ($past(RSTN) |=> DITHER_ACTIVE ==
      ($past(DITHER_ENABLE) && !$past(ADC_POWER_DOWN)))
    else $error("dither state wrong");
  mode_blank_a:
    assert property (OUT_MODE_SEL |=> ADC_DATA == '0)
    else $error("words produced in other mode");
  level_flag_a:
    assert property (EMPTY_FLAG_N[0] == (FIFO_LEVEL[0] != 17'h0)
      && FULL_FLAG_N[0] == (FIFO_LEVEL[0] != 17'h10000))
    else $error("flags disagree with level");
  cover property (vld && scr_r);
  cover property ($rose(ADC_READY));
  cover property (!FULL_FLAG_N[0]);
endmodule

bind adfc_top adfc_top_chk #(.RECOVERY_CYCLES(RECOVERY_CYCLES)) u_chk (
  .CORE_CLK, .RSTN, .OUTPUT_SCRAMBLE_SEL, .GAIN_SELECT, .ADC_POWER_DOWN,
  .DITHER_ENABLE, .FORMAT_SEL, .OUT_MODE_SEL, .RAW_SAMPLE, .ADC_DATA,
  .ADC_DATA_OE, .ADC_READY, .DITHER_ACTIVE, .FULL_FLAG_N, .EMPTY_FLAG_N,
  .FIFO_LEVEL);

// ### testbench/adfc_host_model.sv
`timescale 1ns/1ps
module adfc_host_model
(
  // Clock
  input wire logic  clk,
  // Per-FIFO read enable and output enable
  output logic [3:0] ren_n,
  output logic [3:0] oe_n
);
  initial
  begin
    ren_n = 4'hf;
    oe_n  = 4'hf;
  end
  // One word popped from one FIFO, others untouched
  task automatic pop(input int ch);
    @(posedge clk);
    ren_n[ch] <= 1'b0;
    oe_n[ch]  <= 1'b0;
    @(posedge clk);
    ren_n[ch] <= 1'b1;
  endtask
  // Leading words thrown away
  task automatic skip(input int ch, input int n);
    repeat (n) pop(ch);
  endtask
endmodule

// ### testbench/adc_fifo_capture_control_tb.sv
`timescale 1ns/1ps
module adc_fifo_capture_control_tb;
  localparam int REC = 8;
  localparam logic [34:0] TV [6] = '{
    {3'b110, 16'h0003, 16'h0004}, {3'b110, 16'h6000, 16'h7fff},
    {3'b110, 16'ha000, 16'h8000}, {3'b000, 16'h1234, 16'h9234},
    {3'b011, 16'h0005, 16'hfffb}, {3'b001, 16'h0001, 16'h7fff}};
  logic             clk, rstn, scr, gain, pd, dither_enable, fmt, mode;
  logic             wen_n, prs_n, mrs_n, adc_oe, ready, dither_enable_act;
  logic [3:0][15:0] raw, adc_data, fifo_data;
  logic [3:0]       fifo_oe, ff_n, fe_n;
  logic [3:0][16:0] lvl;
  wire logic [3:0]  ren_n, oe_n;
  int               bad_count = 0;
  int               total_checks = 0;
  adfc_host_model host (.clk(clk), .ren_n(ren_n), .oe_n(oe_n));
  adfc_top #(.RECOVERY_CYCLES(REC)) dut (
    .CORE_CLK(clk), .RSTN(rstn), .OUTPUT_SCRAMBLE_SEL(scr),
    .GAIN_SELECT(gain), .ADC_POWER_DOWN(pd), .DITHER_ENABLE(dither_enable),
    .FORMAT_SEL(fmt), .OUT_MODE_SEL(mode), .RAW_SAMPLE(raw),
    .FIFO_WEN_N(wen_n), .FIFO_REN_N(ren_n), .FIFO_OE_N(oe_n),
    .PARTIAL_CLEAR_N(prs_n), .FULL_CLEAR_N(mrs_n), .ADC_DATA(adc_data),
    .ADC_DATA_OE(adc_oe), .ADC_READY(ready), .DITHER_ACTIVE(dither_enable_act),
    .FIFO_DATA(fifo_data), .FIFO_DATA_OE(fifo_oe), .FULL_FLAG_N(ff_n),
    .EMPTY_FLAG_N(fe_n), .FIFO_LEVEL(lvl));
  always #12.5 clk = ~clk;
  task automatic chk_v(input logic [16:0] g, input logic [16:0] e);
    total_checks++;
    if (g !== e)
    begin
      bad_count++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic chk_f(input logic g, input logic e);
    chk_v({16'h0, g}, {16'h0, e});
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic clr(input logic full);
    @(posedge clk);
    if (full)
      mrs_n <= 1'b0;
    else
      prs_n <= 1'b0;
    @(posedge clk);
    {prs_n, mrs_n} <= 2'b11;
    @(posedge clk);
    @(negedge clk);
  endtask
  task automatic t_power();
    int n;
    n = 0;
    @(negedge clk);
    chk_f(adc_oe, 1'b0);
    @(posedge clk);
    pd <= 1'b0;
    while (ready !== 1'b1 && n < 50)
    begin
      @(negedge clk);
      n++;
    end
    chk_f(n >= REC && n <= REC + 3, 1'b1);
    chk_f(adc_oe, 1'b1);
    $display("t_power done");
  endtask
  task automatic t_path();
    for (int i = 0; i < 6; i++)
    begin
      @(posedge clk);
      {gain, fmt, scr} <= TV[i][34:32];
      raw <= {4{TV[i][31:16]}};
      @(posedge clk);
      @(negedge clk);
      for (int c = 0; c < 4; c++)
        chk_v(adc_data[c], TV[i][15:0]);
      if (i == 4)
        chk_v(adc_data[0] ^ {{15{adc_data[0][0]}}, 1'b0}, 17'h5);
    end
    $display("t_path done");
  endtask
  task automatic t_mode();
    @(posedge clk);
    {mode, dither_enable} <= 2'b11;
    @(posedge clk);
    @(negedge clk);
    chk_v(adc_data[0], 16'h0);
    chk_f(dither_enable_act, 1'b1);
    @(posedge clk);
    {mode, dither_enable} <= 2'b00;
    @(posedge clk);
    @(negedge clk);
    chk_f(dither_enable_act, 1'b0);
    $display("t_mode done");
  endtask
  task automatic t_fifo();
    @(posedge clk);
    {gain, fmt, scr} <= 3'b010;
    clr(1'b0);
    for (int i = 0; i < 6; i++)
    begin
      @(posedge clk);
      for (int c = 0; c < 4; c++)
        raw[c] <= 16'(c * 4096 + i);
      wen_n <= !(i >= 1 && i <= 4);
    end
    @(negedge clk);
    for (int c = 0; c < 4; c++)
      chk_v(lvl[c], 17'h4);
    host.skip(2, 1);
    for (int k = 1; k < 4; k++)
    begin
      host.pop(2);
      @(negedge clk);
      chk_v(fifo_data[2], 16'(8192 + k));
    end
    chk_f(fifo_oe[2], 1'b1);
    chk_v(lvl[1], 17'h4);
    host.pop(2);
    @(negedge clk);
    chk_v(fifo_data[2], 16'h2003);
    chk_f(fe_n[2], 1'b0);
    clr(1'b0);
    chk_v(lvl[1], 17'h0);
    chk_v(fifo_data[2], 16'h2003);
    $display("t_fifo done");
  endtask
  task automatic t_full();
    int n;
    n = 0;
    @(posedge clk);
    wen_n <= 1'b0;
    while (ff_n[0] !== 1'b0 && n < 70000)
    begin
      @(negedge clk);
      n++;
    end
    repeat (3) @(posedge clk);
    @(negedge clk);
    chk_v(lvl[0], 17'h10000);
    chk_f(ff_n[0], 1'b0);
    @(posedge clk);
    wen_n <= 1'b1;
    clr(1'b1);
    chk_v(fifo_data[2], 16'h0);
    chk_f(ff_n[0], 1'b1);
    $display("t_full done");
  endtask
  initial
  begin
    clk = 1'b0;
    rstn = 1'b0;
    raw = '0;
    {scr, gain, dither_enable, mode} = 4'h0;
    {pd, fmt, wen_n, prs_n, mrs_n} = 5'h1f;
    repeat (16) @(posedge clk);
    chk_v(17'(ff_n), 17'hf);
    chk_v(17'(fe_n), 17'h0);
    rstn <= 1'b1;
    t_power();
    t_path();
    t_mode();
    t_fifo();
    t_full();
    finish_test();
  end
  initial
  begin
    #2500000;
    bad_count++;
    finish_test();
  end
endmodule
